// *** rtl/rt_output_port.sv ***
// Notes on behaviour
// - Trigger copies buffer into latch in hardware
// - Each pin selectable port or real-time
// - Dual mode loads halves through separate addresses
// - Byte mode write loads both halves
// - Reads give high:low from either buffer address in both modes
// - Port-mode buffer bits read as zero
// - Reset sets direction register to all ones
// - Reset clears pin mode register
// - Port writes ignored on real-time pins
// - Reset clears control register
// - Dual mode trigger mapping per trigger select
// - Byte mode updates all bits together
// - Bit and byte writes on control registers
`include "rt_port_consts.svh"

module rt_output_port
    import rt_port_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_b,
    input  wire reg_req_s   req,
    input  wire trig_s      trig,
    output logic      [7:0] rdata_q,
    output logic      [7:0] port_out_q,
    output logic      [7:0] port_oe_q,
    output logic            xfer_busy_q
);
    logic [7:0]  direction_q;
    logic [7:0]  pin_mode_q;
    logic [7:0]  control_q;
    logic [3:0]  buf_low_q;
    logic [3:0]  buf_high_q;
    logic [3:0]  buf_low_d;
    logic [3:0]  buf_high_d;
    logic [7:0]  latch_q;
    logic [7:0]  latch_d;
    logic [7:0]  rdata_d;
    logic        upd_low_q;
    logic        upd_high_q;
    logic        upd_low_d;
    logic        upd_high_d;
    trig_state_e state_q;
    trig_state_e state_d;
    logic        mode_byte;
    logic        trig_sel;
    logic [7:0]  buf_word;
    logic [7:0]  upd_mask;
    logic [7:0]  latch_wmask;
    logic        hit_buf_low;
    logic        hit_buf_high;
    logic        hit_direction;
    logic        hit_pin_mode;
    logic        hit_control;
    logic        hit_latch;
    logic        wr_byte;
    logic [7:0]  buf_read;
    logic [7:0]  ctrl_read;
    logic [7:0]  copy_mask;
    logic [7:0]  port_out_d;
    logic [7:0]  port_oe_d;
    logic        xfer_busy_d;

    assign mode_byte = control_q[`RT_CTRL_BYTE_BIT];
    assign trig_sel  = control_q[`RT_CTRL_TRIG_BIT];
    assign buf_word  = {buf_high_q, buf_low_q};
    assign wr_byte   = req.wr && !req.bit_op;
    assign buf_read  = buf_word & pin_mode_q;
    assign ctrl_read = control_q & `RT_CTRL_USED_MASK;
    assign latch_wmask = ~pin_mode_q;

    // Register select decode
    always_comb begin
        hit_buf_low   = 1'b0;
        hit_buf_high  = 1'b0;
        hit_direction = 1'b0;
        hit_pin_mode  = 1'b0;
        hit_control   = 1'b0;
        hit_latch     = 1'b0;
        if (req.sel == `RT_SEL_BUF_LOW) begin
            hit_buf_low = 1'b1;
        end else if (req.sel == `RT_SEL_BUF_HIGH) begin
            hit_buf_high = 1'b1;
        end else if (req.sel == `RT_SEL_DIRECTION) begin
            hit_direction = 1'b1;
        end else if (req.sel == `RT_SEL_PIN_MODE) begin
            hit_pin_mode = 1'b1;
        end else if (req.sel == `RT_SEL_CONTROL) begin
            hit_control = 1'b1;
        end else if (req.sel == `RT_SEL_LATCH) begin
            hit_latch = 1'b1;
        end
    end

    rt_bitreg #(.RST_VAL(`RT_DIRECTION_RST)) u_direction (
        .mclk    (mclk),
        .rst_b   (rst_b),
        .hit     (hit_direction),
        .req     (req),
        .value_q (direction_q)
    );

    rt_bitreg #(.RST_VAL(`RT_PIN_MODE_RST)) u_pin_mode (
        .mclk    (mclk),
        .rst_b   (rst_b),
        .hit     (hit_pin_mode),
        .req     (req),
        .value_q (pin_mode_q)
    );

    rt_bitreg #(.RST_VAL(`RT_CONTROL_RST)) u_control (
        .mclk    (mclk),
        .rst_b   (rst_b),
        .hit     (hit_control),
        .req     (req),
        .value_q (control_q)
    );

    rt_nibble_load u_nibbles (
        .mode_byte (mode_byte),
        .hit_low   (hit_buf_low),
        .hit_high  (hit_buf_high),
        .wr        (wr_byte),
        .wdata     (req.wdata),
        .low_q     (buf_low_q),
        .high_q    (buf_high_q),
        .low_d     (buf_low_d),
        .high_d    (buf_high_d)
    );

    // Trigger decode; flags registered so the copy lands one cycle after the pulse
    always_comb begin
        upd_low_d  = 1'b0;
        upd_high_d = 1'b0;
        case ({mode_byte, trig_sel})
            2'b00: begin
                upd_high_d = trig.tm2;
                upd_low_d  = trig.tm1;
            end
            2'b01: begin
                upd_high_d = trig.tm1;
                upd_low_d  = trig.ext2;
            end
            2'b10: begin
                upd_high_d = trig.tm1;
                upd_low_d  = trig.tm1;
            end
            default: begin
                upd_high_d = trig.ext2;
                upd_low_d  = trig.ext2;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            upd_low_q  <= 1'b0;
            upd_high_q <= 1'b0;
        end else begin
            upd_low_q  <= upd_low_d;
            upd_high_q <= upd_high_d;
        end
    end

    always_comb begin
        case ({upd_high_d, upd_low_d})
            2'b11: begin
                state_d = TRIG_BOTH;
            end
            2'b01, 2'b10: begin
                state_d = TRIG_PEND;
            end
            default: begin
                state_d = TRIG_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_q <= TRIG_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Both halves pending takes the whole buffer
    always_comb begin
        case (state_q)
            TRIG_BOTH: begin
                upd_mask = 8'hff;
            end
            TRIG_PEND: begin
                upd_mask = {{4{upd_high_q}}, {4{upd_low_q}}};
            end
            default: begin
                upd_mask = 8'h00;
            end
        endcase
    end

    assign copy_mask = upd_mask & pin_mode_q;

    always_comb begin
        latch_d = latch_q;
        if (req.wr && hit_latch) begin
            if (req.bit_op) begin
                if (latch_wmask[req.bit_sel]) begin
                    latch_d[req.bit_sel] = req.wdata[0];
                end
            end else begin
                latch_d = (latch_q & ~latch_wmask) | (req.wdata & latch_wmask);
            end
        end
        // Trigger wins over a same-cycle port write, so a late write adds no jitter
        latch_d = (latch_d & ~copy_mask) | (buf_word & copy_mask);
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            latch_q <= `RT_LATCH_RST;
        end else begin
            latch_q <= latch_d;
        end
    end

    // Buffers keep nibbles only; reads rebuild the byte
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            buf_low_q  <= `RT_BUFFER_RST;
            buf_high_q <= `RT_BUFFER_RST;
        end else begin
            buf_low_q  <= buf_low_d;
            buf_high_q <= buf_high_d;
        end
    end

    // Read data stands one cycle, then falls back to zero
    always_comb begin
        rdata_d = 8'h00;
        if (req.rd) begin
            if (hit_buf_low || hit_buf_high) begin
                rdata_d = buf_read;
            end else if (hit_direction) begin
                rdata_d = direction_q;
            end else if (hit_pin_mode) begin
                rdata_d = pin_mode_q;
            end else if (hit_control) begin
                rdata_d = ctrl_read;
            end else if (hit_latch) begin
                rdata_d = latch_q;
            end else begin
                rdata_d = 8'h00;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // Pins follow latch_d, so they move on the same edge as the latch
    always_comb begin
        port_out_d = latch_d;
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            port_out_q <= `RT_LATCH_RST;
        end else begin
            port_out_q <= port_out_d;
        end
    end

    always_comb begin
        port_oe_d = ~direction_q;
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            port_oe_q <= 8'h00;
        end else begin
            port_oe_q <= port_oe_d;
        end
    end

    always_comb begin
        xfer_busy_d = (state_d != TRIG_IDLE);
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            xfer_busy_q <= 1'b0;
        end else begin
            xfer_busy_q <= xfer_busy_d;
        end
    end
endmodule

// *** rtl/rt_port_consts.svh ***
`ifndef RT_PORT_CONSTS_SVH
`define RT_PORT_CONSTS_SVH

// Register selects on the internal special-register port
`define RT_SEL_BUF_LOW   3'h0
`define RT_SEL_BUF_HIGH  3'h1
`define RT_SEL_DIRECTION 3'h2
`define RT_SEL_PIN_MODE  3'h3
`define RT_SEL_CONTROL   3'h4
`define RT_SEL_LATCH     3'h5

// Control register fields
`define RT_CTRL_TRIG_BIT  4
`define RT_CTRL_BYTE_BIT  5
`define RT_CTRL_USED_MASK 8'h30

// Reset values
`define RT_DIRECTION_RST 8'hff
`define RT_PIN_MODE_RST  8'h00
`define RT_CONTROL_RST   8'h00
`define RT_BUFFER_RST    4'h0
`define RT_LATCH_RST     8'h00

`endif

// *** rtl/rt_port_pkg.sv ***
package rt_port_pkg;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       bit_op;
        logic [2:0] bit_sel;
        logic [2:0] sel;
        logic [7:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic tm1;
        logic tm2;
        logic ext2;
    } trig_s;

    typedef enum logic [2:0] {
        TRIG_IDLE = 3'b001,
        TRIG_PEND = 3'b010,
        TRIG_BOTH = 3'b100
    } trig_state_e;

endpackage

// *** rtl/rt_bitreg.sv ***
`include "rt_port_consts.svh"

module rt_bitreg
    import rt_port_pkg::*;
#(
    parameter logic [7:0] RST_VAL = 8'h00
) (
    input  wire logic       mclk,
    input  wire logic       rst_b,
    input  wire logic       hit,
    input  wire reg_req_s   req,
    output logic      [7:0] value_q
);
    logic [7:0] value_d;

    always_comb begin
        value_d = value_q;
        if (hit && req.wr) begin
            if (req.bit_op) begin
                value_d[req.bit_sel] = req.wdata[0];
            end else begin
                value_d = req.wdata;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            value_q <= RST_VAL;
        end else begin
            value_q <= value_d;
        end
    end
endmodule

// *** rtl/rt_nibble_load.sv ***
module rt_nibble_load (
    input  wire logic       mode_byte,
    input  wire logic       hit_low,
    input  wire logic       hit_high,
    input  wire logic       wr,
    input  wire logic [7:0] wdata,
    input  wire logic [3:0] low_q,
    input  wire logic [3:0] high_q,
    output logic      [3:0] low_d,
    output logic      [3:0] high_d
);
    always_comb begin
        low_d  = low_q;
        high_d = high_q;
        if (wr && mode_byte && (hit_low || hit_high)) begin
            low_d  = wdata[3:0];
            high_d = wdata[7:4];
        end else if (wr && hit_low) begin
            low_d = wdata[3:0];
        end else if (wr && hit_high) begin
            high_d = wdata[7:4];
        end
    end
endmodule

// *** tb/rt_port_sva.sv ***
module rt_port_sva
    import rt_port_pkg::*;
(
    input wire logic       mclk,
    input wire logic       rst_b,
    input wire reg_req_s   req,
    input wire trig_s      trig,
    input wire logic [7:0] rdata_q,
    input wire logic [7:0] port_out_q,
    input wire logic [7:0] port_oe_q,
    input wire logic       xfer_busy_q
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    property p_rst; $rose(rst_b) |-> !xfer_busy_q && port_out_q == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("rst");
    property p_oe0; $rose(rst_b) |-> port_oe_q == 8'h00 ##1 port_oe_q == 8'h00; endproperty
    a_oe0: assert property (p_oe0) else $error("oe0");
    property p_oe; req.wr && !req.bit_op && req.sel == 3'h2 |-> ##2 port_oe_q == ~$past(req.wdata, 2); endproperty
    a_oe: assert property (p_oe) else $error("oe");
    property p_oec; $changed(port_oe_q) |-> $past(req.wr && req.sel == 3'h2, 2); endproperty
    a_oec: assert property (p_oec) else $error("oec");
    property p_out; $changed(port_out_q) |-> $past(xfer_busy_q || req.wr && req.sel == 3'h5); endproperty
    a_out: assert property (p_out) else $error("out");
    property p_bsy; xfer_busy_q |-> $past(trig) != 3'h0; endproperty
    a_bsy: assert property (p_bsy) else $error("bsy");
    property p_idl; !req.rd |=> rdata_q == 8'h00; endproperty
    a_idl: assert property (p_idl) else $error("idl");
    property p_unm; req.rd && req.sel > 3'h5 |=> rdata_q == 8'h00; endproperty
    a_unm: assert property (p_unm) else $error("unm");
    cover property (trig.ext2);
    cover property (xfer_busy_q);
    cover property (req.rd && req.sel == 3'h1);
endmodule
bind rt_output_port rt_port_sva chk (.mclk(mclk), .rst_b(rst_b), .req(req), .trig(trig), .rdata_q(rdata_q),
    .port_out_q(port_out_q), .port_oe_q(port_oe_q), .xfer_busy_q(xfer_busy_q));

// *** tb/load_model.sv ***
module load_model (
    input  wire logic [7:0] port_out_q,
    input  wire logic [7:0] port_oe_q,
    output logic      [7:0] coil
);
    timeunit 1ns;
    timeprecision 1ns;
    // Floating pins show inverse so stale data never matches
    assign coil = port_oe_q & port_out_q | ~port_oe_q & ~port_out_q;
endmodule

// *** tb/tb.sv ***
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import rt_port_pkg::*;
    logic       mclk = 1'b0;
    logic       rst_b = 1'b0;
    reg_req_s   req = '0;
    trig_s      trig = '0;
    logic [7:0] rdata_q, port_out_q, port_oe_q, coil, lat, bv, m;
    logic       xfer_busy_q, lo, hi;
    int         bad_count = 0;
    int         checked = 0;
    always #10 mclk = ~mclk;
    rt_output_port dut (.mclk(mclk), .rst_b(rst_b), .req(req), .trig(trig), .rdata_q(rdata_q),
        .port_out_q(port_out_q), .port_oe_q(port_oe_q), .xfer_busy_q(xfer_busy_q));
    load_model load (.port_out_q(port_out_q), .port_oe_q(port_oe_q), .coil(coil));
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic step;
        @(posedge mclk);
        #1;
    endtask
    task automatic acc(input reg_req_s r);
        req = r;
        step();
        req = '0;
    endtask
    task automatic wr(input logic [2:0] s, input logic [7:0] d, input logic b = 1'b0, input logic [2:0] n = 3'h0);
        acc('{1'b1, 1'b0, b, n, s, d});
        step();
    endtask
    task automatic rd(input logic [2:0] s, input logic [7:0] e);
        acc('{1'b0, 1'b1, 1'b0, 3'h0, s, 8'h00});
        cmp(rdata_q, e);
        step();
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #10000;
        bad_count++;
        finish_test();
    end
    initial begin
        repeat (12) @(posedge mclk);
        #1 rst_b = 1'b1;
        rd(3'h2, 8'hff);
        rd(3'h3, 8'h00);
        rd(3'h4, 8'h00);
        wr(3'h5, 8'h3c);
        wr(3'h2, 8'h00);
        cmp(coil, 8'h3c);
        $display("reset test done");
        wr(3'h3, 8'h0f);
        wr(3'h0, 8'ha5);
        wr(3'h1, 8'h7a);
        rd(3'h0, 8'h05);
        wr(3'h3, 8'hff);
        rd(3'h1, 8'h75);
        wr(3'h5, 8'h00);
        cmp(port_out_q, 8'h3c);
        wr(3'h6, 8'h55);
        rd(3'h6, 8'h00);
        wr(3'h3, 8'h3c);
        wr(3'h5, 8'h81);
        lat = 8'hbd;
        cmp(port_out_q, lat);
        $display("buffer test done");
        for (int i = 0; i < 4; i++) begin
            wr(3'h4, {7'h0, i[1]}, 1'b1, 3'h5);
            wr(3'h4, {7'h0, i[0]}, 1'b1, 3'h4);
            rd(3'h4, {2'b00, i[1:0], 4'h0});
            for (int e = 0; e < 3; e++) begin
                bv = 8'h5a ^ 8'(i * 16 + e * 37);
                if (!i[1])
                    wr(3'h0, bv);
                wr(3'h1, bv);
                lo = e == (i[0] ? 2 : 0);
                hi = i[1] ? lo : e == (i[0] ? 0 : 1);
                m = {{4{hi}}, {4{lo}}} & 8'h3c;
                trig = trig_s'(3'b100 >> e);
                step();
                trig = '0;
                cmp({7'h0, xfer_busy_q}, {7'h0, hi | lo});
                step();
                lat = lat & ~m | bv & m;
                cmp(port_out_q, lat);
            end
        end
        $display("trigger test done");
        finish_test();
    end
endmodule
